//--- fts_fuser_supervisor.sv
// fuser heater regulation and safety supervision
module fts_fuser_supervisor
	import fts_pkg::*;
#(
	parameter longint      WARMUP_CYCLES  = WARMUP_CYC,
	parameter longint      HEATER_CYCLES  = HEATER_MAX_CYC,
	parameter logic [7:0]  SETPOINT       = SETPOINT_RST,
	parameter logic [7:0]  HYSTERESIS     = HYST_RST,
	parameter logic [7:0]  WARMUP_TARGET  = WARMUP_RST,
	parameter logic [7:0]  OVERHEAT_LEVEL = OVERHEAT_RST
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	// thermistor converter and comparators (asynchronous)
	input  wire logic [SAMPLE_W-1:0] tempSample,
	input  wire logic                thermistor_shutdown_flag,
	input  wire logic                overheat_relay_cut,
	// power stage
	output logic                     heater_drive_n,
	output logic                     safety_relay,
	// engine and panel
	output logic                     engineRun,
	output fts_code_e                faultCode,
	output fts_fault_s               faultFlags
);
	localparam logic [TMR_W-1:0] WARMUP_LIM = TMR_W'(WARMUP_CYCLES);
	localparam logic [TMR_W-1:0] HEATER_LIM = TMR_W'(HEATER_CYCLES);

	fts_state_s cur_ff;
	fts_state_s nxt_cur;

	logic [SAMPLE_W-1:0] temp;
	logic                therm;
	logic                cut;
	logic                overTemp;
	logic                anyFault;

	// synchronised views only; first stages are read by second stages alone
	// limitation: the converter code must hold for two clocks or more, since a code caught
	// mid-change passes the syncs unfiltered and could trip the overheat check for one sample
	assign temp  = cur_ff.tempSync2;
	assign therm = cur_ff.thermSync[1];
	assign cut   = cur_ff.cutSync[1];
	assign overTemp = (temp >= OVERHEAT_LEVEL);
	assign anyFault = therm || cut || overTemp || (cur_ff.state == FTS_ST_FAULT);

	// next state
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.tempSync1    = tempSample;
		nxt_cur.tempSync2    = cur_ff.tempSync1;
		nxt_cur.thermSync    = {cur_ff.thermSync[0], thermistor_shutdown_flag};
		nxt_cur.cutSync      = {cur_ff.cutSync[0], overheat_relay_cut};
		// heater-on run length counter
		if (cur_ff.heaterOn) begin
			nxt_cur.heaterCnt = cur_ff.heaterCnt + TMR_W'(1);
		end else begin
			nxt_cur.heaterCnt = '0;
		end
		case (cur_ff.state)
			FTS_ST_WARMUP: begin
				nxt_cur.warmupCnt = cur_ff.warmupCnt + TMR_W'(1);
				nxt_cur.heaterOn  = 1'b1;
				if (temp >= WARMUP_TARGET) begin
					nxt_cur.state = FTS_ST_REGUL;
				end else if (cur_ff.warmupCnt >= WARMUP_LIM - TMR_W'(1)) begin
					nxt_cur.faults.warmupTimeout = 1'b1;
				end
			end
			FTS_ST_REGUL: begin
				// bang-bang with a small band to limit thyristor switching
				if (temp >= SETPOINT + HYSTERESIS) begin
					nxt_cur.heaterOn = 1'b0;
				end else if (temp < SETPOINT - HYSTERESIS) begin
					nxt_cur.heaterOn = 1'b1;
				end
			end
			FTS_ST_FAULT: begin
				nxt_cur.heaterOn = 1'b0;
			end
			default: begin
				nxt_cur.state = FTS_ST_FAULT;
			end
		endcase
		if (cur_ff.heaterOn && cur_ff.heaterCnt >= HEATER_LIM - TMR_W'(1)) begin
			nxt_cur.faults.heaterStuck = 1'b1;
		end
		if (therm) begin
			nxt_cur.faults.thermCut = 1'b1;
		end
		if (cut) begin
			nxt_cur.faults.overheat = 1'b1;
		end
		// any latched fault: stop, heater off until reset; relay is left to the overheat/relay-cut logic below
		if (nxt_cur.faults != '0 || anyFault) begin
			nxt_cur.state     = FTS_ST_FAULT;
			nxt_cur.heaterOn  = 1'b0;
			nxt_cur.engineRun = 1'b0;
		end else begin
			nxt_cur.engineRun = (nxt_cur.state == FTS_ST_REGUL);
		end
		// relay opens on overheat or relay-cut and stays open
		nxt_cur.relayClosed = cur_ff.relayClosed && !overTemp && !cut;
		// first code to latch is kept; thermistor cut has top priority
		if (cur_ff.code == FTS_CODE_NONE) begin
			if (nxt_cur.faults.thermCut) begin
				nxt_cur.code = FTS_CODE_THERM_CUT;
			end else if (nxt_cur.faults.overheat) begin
				nxt_cur.code = FTS_CODE_OVERHEAT;
			end else if (nxt_cur.faults.heaterStuck) begin
				nxt_cur.code = FTS_CODE_HEATER_STK;
			end else if (nxt_cur.faults.warmupTimeout) begin
				nxt_cur.code = FTS_CODE_WARMUP_TO;
			end
		end
	end

	// state register; relay starts closed so warm-up can heat
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cur_ff             <= '0;
			cur_ff.state       <= FTS_ST_WARMUP;
			cur_ff.relayClosed <= 1'b1;
			cur_ff.code        <= FTS_CODE_NONE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// outputs straight from the state flops
	assign heater_drive_n = !cur_ff.heaterOn;
	assign safety_relay   = cur_ff.relayClosed;
	assign engineRun      = cur_ff.engineRun;
	assign faultCode      = cur_ff.code;
	assign faultFlags     = cur_ff.faults;

	// checks
	property p_relay_cut;
		@(posedge clk_sys) disable iff (!resetn)
		cur_ff.cutSync[1] |=> !safety_relay;
	endproperty
	a_relay_cut: assert property (p_relay_cut) else $error("relay not opened on cut");

	property p_overheat_relay;
		@(posedge clk_sys) disable iff (!resetn)
		(cur_ff.tempSync2 >= OVERHEAT_LEVEL) |=> (!safety_relay && !engineRun);
	endproperty
	a_overheat_relay: assert property (p_overheat_relay) else $error("overheat not handled");

	property p_therm_code;
		@(posedge clk_sys) disable iff (!resetn)
		$rose(thermistor_shutdown_flag) && faultCode == FTS_CODE_NONE
			|-> ##3 (faultCode == FTS_CODE_THERM_CUT && !engineRun);
	endproperty
	a_therm_code: assert property (p_therm_code) else $error("thermistor cut code missing");

	property p_cut_code;
		@(posedge clk_sys) disable iff (!resetn)
		cut && !cur_ff.faults.thermCut && !therm && faultCode == FTS_CODE_NONE
			|=> faultCode == FTS_CODE_OVERHEAT;
	endproperty
	a_cut_code: assert property (p_cut_code) else $error("overheat code missing");

	property p_fault_latch;
		@(posedge clk_sys) disable iff (!resetn)
		faultCode != FTS_CODE_NONE |=> ($stable(faultCode) && heater_drive_n);
	endproperty
	a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");

	property p_heater_stuck;
		@(posedge clk_sys) disable iff (!resetn)
		(!heater_drive_n && cur_ff.heaterCnt == HEATER_LIM - TMR_W'(1)) |=> faultFlags.heaterStuck;
	endproperty
	a_heater_stuck: assert property (p_heater_stuck) else $error("stuck heater missed");

	property p_warmup_to;
		@(posedge clk_sys) disable iff (!resetn)
		(cur_ff.state == FTS_ST_WARMUP && cur_ff.warmupCnt == WARMUP_LIM - TMR_W'(1)
			&& cur_ff.tempSync2 < WARMUP_TARGET) |=> (faultCode != FTS_CODE_NONE);
	endproperty
	a_warmup_to: assert property (p_warmup_to) else $error("warm-up timeout missed");

	property p_regulate_off;
		@(posedge clk_sys) disable iff (!resetn)
		(cur_ff.state == FTS_ST_REGUL && temp >= SETPOINT + HYSTERESIS) |=> heater_drive_n;
	endproperty
	a_regulate_off: assert property (p_regulate_off) else $error("heater on above setpoint");

	property p_regulate_on;
		@(posedge clk_sys) disable iff (!resetn)
		(cur_ff.state == FTS_ST_REGUL && temp < SETPOINT - HYSTERESIS && !anyFault
			&& cur_ff.heaterCnt < HEATER_LIM - TMR_W'(1)) |=> !heater_drive_n;
	endproperty
	a_regulate_on: assert property (p_regulate_on) else $error("heater off below setpoint");

	// relay never recloses once opened; only reset closes it again
	property p_relay_latch;
		@(posedge clk_sys) disable iff (!resetn)
		!safety_relay |=> !safety_relay;
	endproperty
	a_relay_latch: assert property (p_relay_latch) else $error("relay reclosed");

	// engine may print only with relay closed and no code latched
	property p_run_clean;
		@(posedge clk_sys) disable iff (!resetn)
		engineRun |-> (faultCode == FTS_CODE_NONE && safety_relay);
	endproperty
	a_run_clean: assert property (p_run_clean) else $error("engine running with fault");

	// any latched flag keeps heater and engine off in the same cycle
	property p_fault_off;
		@(posedge clk_sys) disable iff (!resetn)
		(faultFlags != '0) |-> (heater_drive_n && !engineRun);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("heater or engine on with fault");
endmodule

//--- fts_pkg.sv
// constants and carrier types for the fuser temperature supervisor
package fts_pkg;
	localparam int          SAMPLE_W        = 8;
	// temperatures are adc codes, one code per degree C
	localparam logic [7:0]  SETPOINT_RST    = 8'h8c;   // 140 C fixing setpoint
	localparam logic [7:0]  HYST_RST        = 8'h02;   // on/off band half width
	localparam logic [7:0]  WARMUP_RST      = 8'h82;   // warm-up target, 130 C
	localparam logic [7:0]  OVERHEAT_RST    = 8'hc8;   // overheat threshold, 200 C
	localparam int          CLK_MHZ         = 50;
	localparam int          WARMUP_MS       = 60000;
	localparam int          HEATER_MAX_MS   = 90000;
	localparam longint      WARMUP_CYC      = longint'(WARMUP_MS) * 1000 * CLK_MHZ;
	localparam longint      HEATER_MAX_CYC  = longint'(HEATER_MAX_MS) * 1000 * CLK_MHZ;
	localparam int          TMR_W           = 33;

	// fault codes shown on the panel
	typedef enum logic [2:0] {
		FTS_CODE_NONE       = 3'h0,
		FTS_CODE_THERM_CUT  = 3'h1,
		FTS_CODE_WARMUP_TO  = 3'h2,
		FTS_CODE_HEATER_STK = 3'h3,
		FTS_CODE_OVERHEAT   = 3'h4
	} fts_code_e;

	typedef enum logic [2:0] {
		FTS_ST_WARMUP = 3'b001,
		FTS_ST_REGUL  = 3'b010,
		FTS_ST_FAULT  = 3'b100
	} fts_state_e;

	// latched fault flags
	typedef struct packed {
		logic thermCut;
		logic warmupTimeout;
		logic heaterStuck;
		logic overheat;
	} fts_fault_s;

	// whole module state
	typedef struct packed {
		fts_state_e          state;
		logic [SAMPLE_W-1:0] tempSync1;
		logic [SAMPLE_W-1:0] tempSync2;
		logic [1:0]          thermSync;
		logic [1:0]          cutSync;
		logic [TMR_W-1:0]    warmupCnt;
		logic [TMR_W-1:0]    heaterCnt;
		logic                heaterOn;
		logic                relayClosed;
		logic                engineRun;
		fts_fault_s          faults;
		fts_code_e           code;
	} fts_state_s;
endpackage

//--- fts_plant_model.sv
// thermal plant: roller heating, converter and safety comparators
module fts_plant_model
	import fts_pkg::*;
(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	// power stage
	input  wire logic                heater_drive_n,
	input  wire logic                safety_relay,
	// bench control
	input  wire logic                forceEn,
	input  wire logic [SAMPLE_W-1:0] forceTemp,
	input  wire logic                thermTrip,
	input  wire logic                relayTrip,
	// sensing
	output logic      [SAMPLE_W-1:0] tempSample,
	output logic                     thermistor_shutdown_flag,
	output logic                     overheat_relay_cut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [SAMPLE_W-1:0] rollTemp;

	// one code per clock, far faster than a real roller to keep runs short
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rollTemp <= 8'h78;
		else if (forceEn)
			rollTemp <= forceTemp;
		else if (!heater_drive_n && safety_relay)
			rollTemp <= rollTemp + 8'h01;
		else if (rollTemp > 8'h14)
			rollTemp <= rollTemp - 8'h01;
	end

	// comparators pass trips on; no delay since the supervisor syncs them
	assign tempSample               = rollTemp;
	assign thermistor_shutdown_flag = thermTrip;
	assign overheat_relay_cut       = relayTrip;
endmodule

//--- tb.sv
// self-checking bench for the fuser temperature supervisor
module tb
	import fts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0;
	logic       resetn = 1'b0;
	logic       forceEn = 1'b0;
	logic [7:0] forceTemp = 8'h00;
	logic       thermTrip = 1'b0;
	logic       relayTrip = 1'b0;
	logic [7:0] tempSample;
	logic       thermFlag;
	logic       cutFlag;
	logic       heater_drive_n;
	logic       safety_relay;
	logic       engineRun;
	fts_code_e  faultCode;
	fts_fault_s faultFlags;
	int         num_errors = 0;
	int         total_checks = 0;
	int         cycles = 0;
	int         n;

	fts_plant_model plant (.clk_sys(clk_sys), .resetn(resetn), .heater_drive_n(heater_drive_n),
		.safety_relay(safety_relay), .forceEn(forceEn), .forceTemp(forceTemp), .thermTrip(thermTrip),
		.relayTrip(relayTrip), .tempSample(tempSample), .thermistor_shutdown_flag(thermFlag),
		.overheat_relay_cut(cutFlag));
	// short timeouts so fault paths are reached within the run
	fts_fuser_supervisor #(.WARMUP_CYCLES(200), .HEATER_CYCLES(300)) dut (.clk_sys(clk_sys),
		.resetn(resetn), .tempSample(tempSample), .thermistor_shutdown_flag(thermFlag),
		.overheat_relay_cut(cutFlag), .heater_drive_n(heater_drive_n), .safety_relay(safety_relay),
		.engineRun(engineRun), .faultCode(faultCode), .faultFlags(faultFlags));

	// 50 MHz clock and hang guard
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk_code(input fts_code_e got, input fts_code_e exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: code %h not %h", $time, got, exp);
		end
	endtask
	// reset for 20 cycles, optionally pinning the roller temperature
	task automatic start(input logic [7:0] t, input logic f);
		@(posedge clk_sys);
		resetn <= 1'b0;
		forceEn <= f;
		forceTemp <= t;
		thermTrip <= 1'b0;
		relayTrip <= 1'b0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
	endtask
	// bounded waits; n counts cycles since the wait began
	task automatic wait_fault();
		for (n = 0; n < 400 && faultCode === FTS_CODE_NONE; n++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic wait_run();
		for (n = 0; n < 100 && engineRun !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
	endtask
	task automatic t_regulate();
		logic [7:0] mn;
		logic [7:0] mx;
		int on;
		start(8'h00, 1'b0);
		// heater is off while in reset and comes on at the first edge after release
		@(posedge clk_sys);
		#1;
		chk_bit(heater_drive_n, 1'b0);
		wait_run();
		mn = 8'hff;
		mx = 8'h00;
		on = 0;
		repeat (300) begin
			@(posedge clk_sys);
			#1;
			mn = (tempSample < mn) ? tempSample : mn;
			mx = (tempSample > mx) ? tempSample : mx;
			on += (heater_drive_n === 1'b0) ? 1 : 0;
		end
		chk_bit(mn >= 8'h84 && mx <= 8'h94, 1'b1);
		chk_bit(on > 30 && on < 270, 1'b1);
		chk_code(faultCode, FTS_CODE_NONE);
		chk_bit(engineRun, 1'b1);
	endtask
	task automatic t_warmup();
		start(8'h64, 1'b1);
		wait_fault();
		chk_code(faultCode, FTS_CODE_WARMUP_TO);
		chk_bit(n >= 195 && n <= 210, 1'b1);
		chk_bit(faultFlags.warmupTimeout, 1'b1);
		@(posedge clk_sys);
		forceEn <= 1'b0;
		repeat (50) @(posedge clk_sys);
		#1;
		chk_code(faultCode, FTS_CODE_WARMUP_TO);
		chk_bit(heater_drive_n & ~engineRun, 1'b1);
	endtask
	task automatic t_stuck();
		start(8'h87, 1'b1);
		wait_fault();
		chk_code(faultCode, FTS_CODE_HEATER_STK);
		chk_bit(n >= 295 && n <= 310, 1'b1);
		chk_bit(faultFlags.heaterStuck, 1'b1);
		chk_bit(heater_drive_n, 1'b1);
	endtask
	task automatic t_therm();
		start(8'h00, 1'b0);
		wait_run();
		thermTrip <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk_code(faultCode, FTS_CODE_THERM_CUT);
		chk_bit(faultFlags.thermCut & ~engineRun & heater_drive_n, 1'b1);
	endtask
	task automatic t_hot();
		start(8'h00, 1'b0);
		wait_run();
		forceEn <= 1'b1;
		forceTemp <= 8'hc8;
		repeat (4) @(posedge clk_sys);
		#1;
		chk_bit(safety_relay | engineRun, 1'b0);
		chk_code(faultCode, FTS_CODE_NONE);
		start(8'h00, 1'b0);
		wait_run();
		relayTrip <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk_bit(safety_relay, 1'b1);
		@(posedge clk_sys);
		#1;
		chk_bit(safety_relay | engineRun | ~heater_drive_n, 1'b0);
		chk_code(faultCode, FTS_CODE_OVERHEAT);
		chk_bit(faultFlags.overheat, 1'b1);
	endtask

	initial begin
		t_regulate();
		t_warmup();
		t_stuck();
		t_therm();
		t_hot();
		close_out();
	end
endmodule
